// *** rtl/uhs_map.svh ***
// Constants for the host-select, baud and clear-to-send pin block
// Overview of operation
// R1: The baud clock output is the 16x bit rate clock of the transmitter.
// R2: The baud clock rate is the reference clock over the divisor value; at divisor one the code holds the output high.
// R3: The board may tie the baud clock output to the receiver clock input.
// R4: Selected only with both high selects high and the low select low.
// R5: Any inactive select leaves the device idle, ignoring reads and writes.
// R6: A modem status read returns the current clear-to-send level in bit 4.
// R7: Status bit 0 sets on a clear-to-send change since the last read.
// R8: A clear-to-send change interrupts if enabled and auto gating is off.
// R9: With auto gating on, clear-to-send permits or holds the transmitter.
// R10: The data bus is eight bidirectional lines with three-state drivers.
// R11: Data bus drivers stay off except during a selected host read.
// R12: The three register select lines choose the register accessed.
// R13: Selects pass while the address strobe is low and hold while high.
// R14: The receiver counts receiver clock input cycles at 16 per bit.
`ifndef UHS_MAP_SVH
`define UHS_MAP_SVH
`define UHS_REG_RBR 3'h0
`define UHS_REG_IER 3'h1
`define UHS_REG_LCR 3'h3
`define UHS_REG_MCR 3'h4
`define UHS_REG_MSR 3'h6
`define UHS_REG_SCR 3'h7
`define UHS_MSR_CTS 4
`define UHS_MSR_DCTS 0
`define UHS_IER_MS 3
`define UHS_LCR_DLAB 7
`define UHS_MCR_AFE 5
`define UHS_DIV_RESET 16'h0001
`define UHS_RX_LAST 4'hf
`endif

// *** rtl/uhs_pkg.sv ***
// Types for the host-select, baud and clear-to-send pin block
`default_nettype none
package uhs_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic sel_a;
    logic sel_b;
    logic sel_n;
  } uhs_sel_t;
  typedef struct packed {
    uhs_sel_t held;
    logic [15:0] div;
    logic [15:0] cnt;
    logic baud;
    logic [3:0] rx_cnt;
    logic rx_tick;
    logic rx_prev;
    logic [7:0] ier;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [7:0] scr;
    logic cts_prev;
    logic dcts;
    logic irq;
    logic tx_permit;
    logic [7:0] dout;
    logic doe;
    logic rd_prev;
  } uhs_state_t;
endpackage : uhs_pkg
`default_nettype wire

// *** rtl/uhs_pins.sv ***
// Chip select, address latch, baud generator and clear-to-send status
`include "uhs_map.svh"
`default_nettype none
module uhs_pins #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic chip_select_high_a,
  input wire logic chip_select_high_b,
  input wire logic chip_select_low_n,
  input wire logic address_latch_strobe_n,
  input wire logic register_select_0,
  input wire logic register_select_1,
  input wire logic register_select_2,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic cts_n,
  input wire logic rx_clock_in,
  output logic baud_clock_out,
  output logic rx_sample_tick,
  output logic tx_permit,
  output logic modem_irq
);
  if (DATA_W != 8)
  begin : g_width_check
    $error("uhs_pins supports an eight-bit data bus only");
  end

  uhs_pkg::uhs_state_t s_q;
  uhs_pkg::uhs_state_t s_d;
  uhs_pkg::uhs_sel_t live;
  uhs_pkg::uhs_sel_t eff;
  logic sel;
  logic rd;
  logic wr;
  logic cts;
  logic auto_cts;
  logic [7:0] msr;

  function automatic logic selected(input uhs_pkg::uhs_sel_t x);
    selected = x.sel_a & x.sel_b & ~x.sel_n; // R4 R5
  endfunction : selected

  always_comb
  begin
    live.addr = {register_select_2, register_select_1, register_select_0};
    live.sel_a = chip_select_high_a;
    live.sel_b = chip_select_high_b;
    live.sel_n = chip_select_low_n;
    eff = address_latch_strobe_n ? s_q.held : live; // R13
    sel = selected(eff);
    rd = sel & ~rd_n; // R5
    wr = sel & ~wr_n; // R5
    cts = ~cts_n;
    auto_cts = s_q.mcr[`UHS_MCR_AFE];
    msr = 8'h00;
    msr[`UHS_MSR_CTS] = cts; // R6
    msr[`UHS_MSR_DCTS] = s_q.dcts;
  end

  always_comb
  begin
    s_d = s_q;
    if (!address_latch_strobe_n)
      s_d.held = live; // R13
    s_d.rd_prev = rd;
    // Baud divider: half period toggles give the 16x clock
    if (s_q.cnt >= s_q.div - 16'h0001)
    begin
      s_d.cnt = 16'h0000;
      s_d.baud = 1'b1; // R1 R2
    end
    else
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
      if (s_q.cnt == ((s_q.div - 16'h0001) >> 1))
        s_d.baud = 1'b0; // R2
    end
    // Receiver timing counts rising edges of the receiver clock
    s_d.rx_prev = rx_clock_in;
    s_d.rx_tick = 1'b0;
    if (rx_clock_in && !s_q.rx_prev)
    begin
      s_d.rx_cnt = s_q.rx_cnt + 4'h1; // R14
      s_d.rx_tick = (s_q.rx_cnt == `UHS_RX_LAST); // R14
    end
    // Change flag: set wins over clear on read
    s_d.cts_prev = cts;
    if (rd && !s_q.rd_prev && eff.addr == `UHS_REG_MSR)
      s_d.dcts = 1'b0; // R7
    if (cts != s_q.cts_prev)
      s_d.dcts = 1'b1; // R7
    s_d.irq = s_d.dcts & s_q.ier[`UHS_IER_MS] & ~auto_cts; // R8
    s_d.tx_permit = ~auto_cts | cts; // R9
    if (wr)
    begin
      case (eff.addr) // R12
        `UHS_REG_RBR:
        begin
          if (s_q.lcr[`UHS_LCR_DLAB])
            s_d.div[7:0] = data_in;
        end
        `UHS_REG_IER:
        begin
          if (s_q.lcr[`UHS_LCR_DLAB])
            s_d.div[15:8] = data_in;
          else
            s_d.ier = data_in;
        end
        `UHS_REG_LCR: s_d.lcr = data_in;
        `UHS_REG_MCR: s_d.mcr = data_in;
        `UHS_REG_SCR: s_d.scr = data_in;
        default: s_d.scr = s_q.scr;
      endcase
    end
    if (s_d.div == 16'h0000)
      s_d.div = s_q.div;
    s_d.doe = rd; // R10 R11
    s_d.dout = 8'h00;
    case (eff.addr) // R12
      `UHS_REG_RBR: s_d.dout = s_q.lcr[`UHS_LCR_DLAB] ? s_q.div[7:0] : 8'h00;
      `UHS_REG_IER:
        s_d.dout = s_q.lcr[`UHS_LCR_DLAB] ? s_q.div[15:8] : s_q.ier;
      `UHS_REG_LCR: s_d.dout = s_q.lcr;
      `UHS_REG_MCR: s_d.dout = s_q.mcr;
      `UHS_REG_MSR: s_d.dout = msr; // R6
      `UHS_REG_SCR: s_d.dout = s_q.scr;
      default: s_d.dout = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.div <= `UHS_DIV_RESET;
      s_q.tx_permit <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign data_out = s_q.dout;
  assign data_oe = s_q.doe;
  assign baud_clock_out = s_q.baud;
  assign rx_sample_tick = s_q.rx_tick;
  assign tx_permit = s_q.tx_permit;
  assign modem_irq = s_q.irq;

  chk_oe_needs_sel: assert property (@(posedge clock) // R11
    disable iff (!resetn)
    data_oe |-> $past(rd))
  else
    $error("bus driven without selected read");

  chk_unsel_quiet: assert property (@(posedge clock) // R11
    disable iff (!resetn)
    !sel |=> !data_oe)
  else
    $error("bus driven while unselected");

  chk_unsel_no_write: assert property (@(posedge clock) // R5
    disable iff (!resetn)
    !sel |=> s_q.mcr == $past(s_q.mcr))
  else
    $error("write while unselected");

  chk_dcts_set: assert property (@(posedge clock) // R7
    disable iff (!resetn)
    (cts != s_q.cts_prev) |=> s_q.dcts)
  else
    $error("cts change not flagged");

  chk_dcts_clear: assert property (@(posedge clock) // R7
    disable iff (!resetn)
    rd && !s_q.rd_prev && eff.addr == `UHS_REG_MSR &&
    cts == s_q.cts_prev |=> !s_q.dcts)
  else
    $error("change flag not cleared by status read");

  chk_irq_raise: assert property (@(posedge clock) // R8
    disable iff (!resetn)
    (cts != s_q.cts_prev) && s_q.ier[`UHS_IER_MS] && !auto_cts
    |=> modem_irq)
  else
    $error("cts change raised no irq");

  chk_irq_auto_off: assert property (@(posedge clock) // R8
    disable iff (!resetn)
    $past(auto_cts) && auto_cts |-> !modem_irq)
  else
    $error("irq in auto mode");

  chk_tx_gate: assert property (@(posedge clock) // R9
    disable iff (!resetn)
    auto_cts && cts_n && $stable(s_q.mcr) |=> !tx_permit)
  else
    $error("tx not held");

  chk_tx_free: assert property (@(posedge clock) // R9
    disable iff (!resetn)
    !auto_cts || !cts_n |=> tx_permit)
  else
    $error("tx held without cause");

  chk_msr_cts: assert property (@(posedge clock) // R6
    disable iff (!resetn)
    rd && eff.addr == `UHS_REG_MSR
    |=> data_out[`UHS_MSR_CTS] == !$past(cts_n))
  else
    $error("cts bit wrong");

  chk_hold_addr: assert property (@(posedge clock) // R13
    disable iff (!resetn)
    address_latch_strobe_n && $past(address_latch_strobe_n)
    |-> $stable(s_q.held))
  else
    $error("latch moved");

  chk_baud_period: assert property (@(posedge clock) // R2
    disable iff (!resetn)
    $rose(baud_clock_out) && s_q.div == 16'h0004 && $stable(s_q.div)
    |-> ##4 $rose(baud_clock_out))
  else
    $error("baud period wrong");

  chk_baud_div_one: assert property (@(posedge clock) // R2
    disable iff (!resetn)
    s_q.div == 16'h0001 |=> baud_clock_out)
  else
    $error("baud not high at divisor one");

  chk_tick_on_edge: assert property (@(posedge clock) // R14
    disable iff (!resetn)
    rx_sample_tick |-> $past(rx_clock_in) && !$past(rx_clock_in, 2))
  else
    $error("rx tick without receiver clock edge");
endmodule : uhs_pins
`default_nettype wire

// *** tb/uhs_modem.sv ***
// Modem and board link model at the serial side
`default_nettype none
module uhs_modem (
  input wire logic clock,
  input wire logic cts_req,
  input wire logic baud_clock_out,
  output var logic cts_n = 1'b1,
  output logic rx_clock_in
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(negedge clock) cts_n <= !cts_req;
  assign rx_clock_in = baud_clock_out;
endmodule : uhs_modem
`default_nettype wire

// *** tb/testbench.sv ***
// Bench for the host-select, baud and clear-to-send pin block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, sa = 1, sb = 1, sn = 0, ads_n = 0;
  logic rd_n = 1, wr_n = 1, cts_req = 0, cts_n, rxc;
  logic [2:0] adr = 0;
  logic [7:0] din = 0, dout;
  logic oe, baud, tick, permit, irq;
  int bad_count = 0, check_count = 0;
  always #2 clock = ~clock;
  uhs_modem modem (.clock(clock), .cts_req(cts_req),
    .baud_clock_out(baud), .cts_n(cts_n), .rx_clock_in(rxc));
  uhs_pins uut (.clock(clock), .resetn(resetn),
    .chip_select_high_a(sa), .chip_select_high_b(sb),
    .chip_select_low_n(sn), .address_latch_strobe_n(ads_n),
    .register_select_0(adr[0]), .register_select_1(adr[1]),
    .register_select_2(adr[2]), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .cts_n(cts_n),
    .rx_clock_in(rxc), .baud_clock_out(baud), .rx_sample_tick(tick),
    .tx_permit(permit), .modem_irq(irq));
  task automatic chk(input string n, input logic [7:0] e, s);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
    @(negedge clock);
    adr = a;
    din = d;
    rd_n = w;
    wr_n = !w;
    @(negedge clock);
    rd_n = 1;
    wr_n = 1;
  endtask : acc
  task automatic cts_to(input logic v);
    cts_req = v;
    repeat (4) @(negedge clock);
  endtask : cts_to
  task automatic t_select();
    for (int i = 0; i < 4; i++)
    begin
      sa = i != 0;
      sb = i != 1;
      sn = i == 2;
      acc(3'h6, 0, 8'h00);
      chk("bus drive", {7'h00, i == 3}, {7'h00, oe});
    end
  endtask : t_select
  task automatic t_latch();
    @(negedge clock);
    ads_n = 1;
    sa = 0;
    acc(3'h6, 0, 8'h00);
    chk("latched select", 8'h01, {7'h00, oe});
    ads_n = 0;
    acc(3'h6, 0, 8'h00);
    chk("live select", 8'h00, {7'h00, oe});
    sa = 1;
  endtask : t_latch
  task automatic t_cts();
    cts_to(1);
    acc(3'h6, 0, 8'h00);
    chk("status change", 8'h11, dout);
    acc(3'h6, 0, 8'h00);
    chk("status after read", 8'h10, dout);
    acc(3'h1, 1, 8'h08);
    cts_to(0);
    chk("status irq", 8'h01, {7'h00, irq});
    acc(3'h6, 0, 8'h00);
    @(negedge clock);
    chk("irq cleared", 8'h00, {7'h00, irq});
    acc(3'h4, 1, 8'h20);
    @(negedge clock);
    chk("send held", 8'h00, {7'h00, permit});
    cts_to(1);
    chk("send allowed", 8'h01, {7'h00, permit});
    chk("auto irq off", 8'h00, {7'h00, irq});
  endtask : t_cts
  task automatic t_baud();
    int rises, ticks;
    logic prev;
    rises = 0;
    ticks = 0;
    acc(3'h3, 1, 8'h80);
    acc(3'h0, 1, 8'h04);
    acc(3'h1, 1, 8'h00);
    acc(3'h3, 1, 8'h00);
    repeat (8) @(negedge clock);
    prev = baud;
    repeat (64)
    begin
      @(negedge clock);
      rises += int'(baud && !prev);
      ticks += int'(tick === 1'b1);
      prev = baud;
    end
    chk("baud rises", 8'h10, rises[7:0]);
    chk("rx tick", 8'h01, ticks[7:0]);
  endtask : t_baud
  task automatic t_regs();
    acc(3'h7, 1, 8'h5a);
    acc(3'h7, 0, 8'h00);
    chk("scratch read", 8'h5a, dout);
    acc(3'h1, 0, 8'h00);
    chk("enable read", 8'h08, dout);
    sa = 0;
    acc(3'h7, 1, 8'ha5);
    sa = 1;
    acc(3'h7, 0, 8'h00);
    chk("unselected write", 8'h5a, dout);
  endtask : t_regs
  task automatic finish_test();
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (20) @(negedge clock);
    resetn = 1;
    chk("reset state", 8'h02, {6'h00, permit, oe});
    t_select();
    t_latch();
    t_cts();
    t_regs();
    t_baud();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
